// File: hdl/scph_map.vh
`ifndef SCPH_MAP_VH
`define SCPH_MAP_VH

// byte framing on the control port
`define SCPH_BYTE_BITS   8
`define SCPH_BIT_CNT_W   3
`define SCPH_BIT_LAST    3'h7

// pcm highway layout
`define SCPH_CHANNELS    4
`define SCPH_SLOT_W      7
`define SCPH_LIN_BITS    16
`define SCPH_SIGN_BIT    13
`define SCPH_DELAY_W     3
`define SCPH_POS_W       11
`define SCPH_POS_MAX     11'h7FF

// received byte buffer
`define SCPH_FIFO_WIDTH  9
`define SCPH_FIFO_DEPTH  16

// reset values
`define SCPH_RST_OE_N    1'b1
`define SCPH_RST_IND_N   1'b1
`define SCPH_RST_DATA    1'b0

`endif

// File: hdl/scph_fifo.v
`timescale 1ns/1ps
module scph_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire             clk_i,
  input  wire             rst_n_i,
  // fill side
  input  wire             in_valid_i,
  input  wire [WIDTH-1:0] in_data_i,
  output reg              in_ready_o,
  // drain side
  output reg              out_valid_o,
  output wire [WIDTH-1:0] out_data_o,
  input  wire             out_ready_i
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;
  wire [AW:0]     next_count;

  assign push       = in_valid_i & in_ready_o;
  assign pop        = out_valid_o & out_ready_i;
  assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign out_data_o = mem[rd_ptr];

  // storage has no reset, only pointers, count and flags do
  always @(posedge clk_i)
  begin
    if (push)
      mem[wr_ptr] <= in_data_i;
  end

  // pointers and registered flags
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr      <= {AW{1'b0}};
      rd_ptr      <= {AW{1'b0}};
      count       <= {(AW+1){1'b0}};
      in_ready_o  <= 1'b0;
      out_valid_o <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      count       <= next_count;
      in_ready_o  <= (next_count != DEPTH);
      out_valid_o <= (next_count != {(AW+1){1'b0}});
    end
  end

endmodule // scph_fifo

// File: hdl/scph_top.v
// How it works
// - control traffic moves as whole bytes
// - port ignored while select is high
// - sample input on rise, drive output on fall
// - first byte is command, rest are data
// - no commands during reply; select high aborts
// - pcm bit rate full or half bit clock
// - pcm edge is rising or falling, global
// - slot start delayed zero to seven bits
// - slot count follows bit clock rate
// - compressed sample fills one selected slot
// - linear word sign-extends bit 13
// - linear field n picks slots 2n, 2n+1
// - per-channel transmit highway choice
// - transmit most significant bit first
// - per-channel receive highway, msb first
// - frame sync marks first time slot
// - indicator pulled low while highway driven
// - control output drives only during replies
`timescale 1ns/1ps
`include "scph_map.vh"
module scph_top #(
  parameter CH = `SCPH_CHANNELS
) (
  // clock and reset
  input  wire              clk_i,
  input  wire              rst_n_i,
  // serial control port pins
  input  wire              ctl_clk_i,
  input  wire              ctl_sel_n_i,
  input  wire              ctl_si_i,
  output reg               ctl_so_o,
  output reg               ctl_so_oe_n_o,
  // received bytes towards the user
  output wire              byte_valid_o,
  output wire [7:0]        byte_data_o,
  output wire              byte_is_cmd_o,
  input  wire              byte_ready_i,
  output reg               overrun_o,
  input  wire              overrun_clr_i,
  // reply bytes from the user
  input  wire              reply_en_i,
  input  wire [7:0]        reply_data_i,
  output reg               reply_taken_o,
  // pcm highway pins
  input  wire              bclk_i,
  input  wire              fs_i,
  input  wire              rx_a_i,
  input  wire              rx_b_i,
  output reg               tx_a_o,
  output reg               tx_a_oe_n_o,
  output reg               tx_b_o,
  output reg               tx_b_oe_n_o,
  output reg               ind_a_n_o,
  output reg               ind_a_oe_n_o,
  output reg               ind_b_n_o,
  output reg               ind_b_oe_n_o,
  // global pcm configuration
  input  wire              half_rate_i,
  input  wire              fall_edge_i,
  input  wire [2:0]        slot_delay_i,
  input  wire              linear_i,
  // per-channel slot and highway configuration
  input  wire [CH*7-1:0]   tx_slot_i,
  input  wire [CH*7-1:0]   rx_slot_i,
  input  wire [CH-1:0]     tx_hwy_i,
  input  wire [CH-1:0]     rx_hwy_i,
  // sample exchange with the voice path
  input  wire [CH*16-1:0]  tx_sample_i,
  output reg  [CH*16-1:0]  rx_sample_o,
  output reg  [CH-1:0]     rx_sample_valid_o
);

  ////////////////////////////////////////////////////////////////////////
  // reset release

  reg rst_s1;
  reg rst_s2;

  // async assert, clean release
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  reg [2:0] control_port_clock_s;
  reg [1:0] sel_s;
  reg [1:0] si_s;
  reg [2:0] bclk_s;
  reg [1:0] fs_s;
  reg [1:0] rxa_s;
  reg [1:0] rxb_s;

  // two flops per pin; third clock flop only feeds edge detect
  always @(posedge clk_i or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      control_port_clock_s <= 3'h0;
      sel_s  <= 2'h3;
      si_s   <= 2'h0;
      bclk_s <= 3'h0;
      fs_s   <= 2'h0;
      rxa_s  <= 2'h0;
      rxb_s  <= 2'h0;
    end
    else
    begin
      control_port_clock_s <= {control_port_clock_s[1:0], ctl_clk_i};
      sel_s  <= {sel_s[0], ctl_sel_n_i};
      si_s   <= {si_s[0], ctl_si_i};
      bclk_s <= {bclk_s[1:0], bclk_i};
      fs_s   <= {fs_s[0], fs_i};
      rxa_s  <= {rxa_s[0], rx_a_i};
      rxb_s  <= {rxb_s[0], rx_b_i};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial control port

  wire                       cc_rise = control_port_clock_s[1] & ~control_port_clock_s[2];
  wire                       cc_fall = ~control_port_clock_s[1] & control_port_clock_s[2];
  wire                       sel_on  = ~sel_s[1];
  reg  [`SCPH_BIT_CNT_W-1:0] bit_cnt;
  reg  [7:0]                 sh_in;
  reg  [7:0]                 sh_out;
  reg                        got_cmd;
  reg                        reply_on;
  reg                        push_v;
  reg  [8:0]                 push_d;
  wire                       fifo_in_ready;
  wire [8:0]                 fifo_out;

  // byte assembly on rising control clock, replies on falling
  always @(posedge clk_i or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      bit_cnt       <= {`SCPH_BIT_CNT_W{1'b0}};
      sh_in         <= 8'h00;
      sh_out        <= 8'h00;
      got_cmd       <= 1'b0;
      reply_on      <= 1'b0;
      push_v        <= 1'b0;
      push_d        <= 9'h000;
      reply_taken_o <= 1'b0;
      ctl_so_o      <= `SCPH_RST_DATA;
      ctl_so_oe_n_o <= `SCPH_RST_OE_N;
    end
    else
    begin
      push_v        <= 1'b0;
      reply_taken_o <= 1'b0;
      if (!sel_on)
      begin
        // select high ends the command and aborts any reply
        bit_cnt       <= {`SCPH_BIT_CNT_W{1'b0}};
        got_cmd       <= 1'b0;
        reply_on      <= 1'b0;
        ctl_so_oe_n_o <= 1'b1;
      end
      else
      begin
        if (cc_rise)
        begin
          sh_in   <= {sh_in[6:0], si_s[1]};
          bit_cnt <= bit_cnt + 1'b1;
          if (bit_cnt == `SCPH_BIT_LAST)
          begin
            // whole byte in hand
            push_v  <= ~reply_on;
            push_d  <= {~got_cmd, sh_in[6:0], si_s[1]};
            got_cmd <= 1'b1;
            if (reply_en_i)
            begin
              reply_on      <= 1'b1;
              sh_out        <= reply_data_i;
              reply_taken_o <= 1'b1;
            end
          end
        end
        if (cc_fall && reply_on)
        begin
          ctl_so_o      <= sh_out[7];
          sh_out        <= {sh_out[6:0], 1'b0};
          ctl_so_oe_n_o <= 1'b0;
        end
      end
    end
  end

  // lost bytes when the user drains too slowly; set beats clear
  always @(posedge clk_i or negedge rst_s2)
  begin
    if (!rst_s2)
      overrun_o <= 1'b0;
    else if (push_v && !fifo_in_ready)
      overrun_o <= 1'b1;
    else if (overrun_clr_i)
      overrun_o <= 1'b0;
  end

  // bytes wait here; the serial side cannot be stalled
  scph_fifo #(
    .WIDTH (`SCPH_FIFO_WIDTH),
    .DEPTH (`SCPH_FIFO_DEPTH),
    .AW    (4)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_s2),
    .in_valid_i  (push_v),
    .in_data_i   (push_d),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (byte_valid_o),
    .out_data_o  (fifo_out),
    .out_ready_i (byte_ready_i)
  );

  assign byte_is_cmd_o = fifo_out[8];
  assign byte_data_o   = fifo_out[7:0];

  ////////////////////////////////////////////////////////////////////////
  // pcm bit timing

  wire                   b_edge = fall_edge_i ? (~bclk_s[1] & bclk_s[2])
                                              : (bclk_s[1] & ~bclk_s[2]);
  reg                    fs_prev;
  reg                    phase;
  reg  [`SCPH_POS_W-1:0] frame_cnt;
  wire                   fs_rise = b_edge & fs_s[1] & ~fs_prev;
  wire                   tick    = b_edge & (fs_rise | ~half_rate_i | phase);
  wire [`SCPH_POS_W-1:0] delay_w = {{(`SCPH_POS_W-3){1'b0}}, slot_delay_i};
  wire [`SCPH_POS_W-1:0] next_cnt;
  wire [`SCPH_POS_W-1:0] tx_pos;
  wire [`SCPH_POS_W-1:0] rx_pos;
  wire                   tx_in;
  wire                   rx_in;

  assign next_cnt = fs_rise ? {`SCPH_POS_W{1'b0}}
                  : (frame_cnt == `SCPH_POS_MAX) ? frame_cnt
                  : frame_cnt + 1'b1;
  assign tx_pos = next_cnt - delay_w;
  assign rx_pos = frame_cnt - delay_w;
  assign tx_in  = (next_cnt >= delay_w);
  assign rx_in  = (frame_cnt >= delay_w);

  // frame counter advances once per pcm bit
  always @(posedge clk_i or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      fs_prev   <= 1'b0;
      phase     <= 1'b0;
      frame_cnt <= `SCPH_POS_MAX;
    end
    else if (b_edge)
    begin
      fs_prev <= fs_s[1];
      phase   <= fs_rise ? 1'b0 : ~phase;
      if (tick)
        frame_cnt <= next_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-channel slot match, transmit and receive

  wire [CH-1:0] drv_a;
  wire [CH-1:0] drv_b;
  wire [CH-1:0] bit_a;
  wire [CH-1:0] bit_b;

  genvar c;
  generate
    for (c = 0; c < CH; c = c + 1)
    begin : g_ch
      wire [6:0]  tsel = tx_slot_i[c*7 +: 7];
      wire [6:0]  rsel = rx_slot_i[c*7 +: 7];
      wire [15:0] smp  = tx_sample_i[c*16 +: 16];
      wire [15:0] word = linear_i ? {smp[`SCPH_SIGN_BIT], smp[`SCPH_SIGN_BIT], smp[13:0]}
                                  : {smp[7:0], 8'h00};
      // linear uses the slot pair, index inside is 4 bits
      wire        t_hit = tx_in & (linear_i ? (tx_pos[9:4] == tsel[5:0]) & ~tsel[6]
                                            : (tx_pos[9:3] == tsel));
      wire [3:0]  t_idx = linear_i ? tx_pos[3:0] : {1'b0, tx_pos[2:0]};
      wire        r_hit = rx_in & (linear_i ? (rx_pos[9:4] == rsel[5:0]) & ~rsel[6]
                                            : (rx_pos[9:3] == rsel));
      wire        r_end = linear_i ? (rx_pos[3:0] == 4'hF) : (rx_pos[2:0] == 3'h7);
      wire        t_bit = word[4'hF - t_idx];
      reg  [15:0] rsh;

      assign drv_a[c] = t_hit & ~tx_pos[10] & ~tx_hwy_i[c];
      assign drv_b[c] = t_hit & ~tx_pos[10] & tx_hwy_i[c];
      assign bit_a[c] = drv_a[c] & t_bit;
      assign bit_b[c] = drv_b[c] & t_bit;

      // receive shift, msb first, from the chosen highway
      always @(posedge clk_i or negedge rst_s2)
      begin
        if (!rst_s2)
        begin
          rsh                    <= 16'h0000;
          rx_sample_o[c*16 +: 16] <= 16'h0000;
          rx_sample_valid_o[c]   <= 1'b0;
        end
        else
        begin
          rx_sample_valid_o[c] <= 1'b0;
          if (tick && r_hit && !rx_pos[10])
          begin
            rsh <= {rsh[14:0], rx_hwy_i[c] ? rxb_s[1] : rxa_s[1]};
            if (r_end)
            begin
              rx_sample_o[c*16 +: 16] <= linear_i
                ? {rsh[14:0], rx_hwy_i[c] ? rxb_s[1] : rxa_s[1]}
                : {8'h00, rsh[6:0], rx_hwy_i[c] ? rxb_s[1] : rxa_s[1]};
              rx_sample_valid_o[c]   <= 1'b1;
            end
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // highway pin drivers

  // launch on the selected edge; idle slots float
  always @(posedge clk_i or negedge rst_s2)
  begin
    if (!rst_s2)
    begin
      tx_a_o       <= `SCPH_RST_DATA;
      tx_a_oe_n_o  <= `SCPH_RST_OE_N;
      tx_b_o       <= `SCPH_RST_DATA;
      tx_b_oe_n_o  <= `SCPH_RST_OE_N;
      ind_a_n_o    <= `SCPH_RST_IND_N;
      ind_a_oe_n_o <= `SCPH_RST_OE_N;
      ind_b_n_o    <= `SCPH_RST_IND_N;
      ind_b_oe_n_o <= `SCPH_RST_OE_N;
    end
    else if (tick)
    begin
      tx_a_o       <= |bit_a;
      tx_a_oe_n_o  <= ~(|drv_a);
      tx_b_o       <= |bit_b;
      tx_b_oe_n_o  <= ~(|drv_b);
      ind_a_n_o    <= 1'b0;
      ind_a_oe_n_o <= ~(|drv_a);
      ind_b_n_o    <= 1'b0;
      ind_b_oe_n_o <= ~(|drv_b);
    end
  end

endmodule // scph_top

// File: testbench/scph_checker.sv
`timescale 1ns/1ps
module scph_checker #(
  parameter CH = 4
) (
  // clock and reset
  input wire          clk_i,
  input wire          rst_n_i,
  // control port
  input wire          ctl_sel_n_i,
  input wire          ctl_so_oe_n_o,
  input wire          byte_valid_o,
  input wire [7:0]    byte_data_o,
  input wire          byte_ready_i,
  input wire          overrun_o,
  input wire          overrun_clr_i,
  input wire          reply_taken_o,
  // pcm highways
  input wire [CH-1:0] tx_hwy_i,
  input wire          tx_a_oe_n_o,
  input wire          tx_b_oe_n_o,
  input wire          ind_a_n_o,
  input wire          ind_a_oe_n_o,
  input wire          ind_b_oe_n_o,
  input wire [CH-1:0] rx_sample_valid_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // select held high long enough to pass the synchronisers
  sequence sel_idle;
    ctl_sel_n_i [*8];
  endsequence
  sequence taken_gap;
    !reply_taken_o [*8];
  endsequence
  a_so_release: assert property (sel_idle |-> ctl_so_oe_n_o)
    else $error("reply line driven while deselected");
  a_so_selected: assert property (!ctl_so_oe_n_o |-> !$past(ctl_sel_n_i, 5))
    else $error("reply line driven without select");
  a_ind_a_low: assert property (!tx_a_oe_n_o |-> !ind_a_oe_n_o && !ind_a_n_o)
    else $error("indicator a not pulled while driving");
  a_ind_b_same: assert property (ind_b_oe_n_o == tx_b_oe_n_o)
    else $error("indicator b differs from highway b");
  a_hwy_b_idle: assert property (!tx_b_oe_n_o |-> (|tx_hwy_i) || (|$past(tx_hwy_i, 40)))
    else $error("highway b driven with no channel on it");
  a_hwy_a_idle: assert property (!tx_a_oe_n_o |-> !(&tx_hwy_i) || !(&$past(tx_hwy_i, 40)))
    else $error("highway a driven with no channel on it");
  a_taken_byte: assert property (reply_taken_o |=> taken_gap)
    else $error("reply loads closer than a byte");
  a_head_hold: assert property (byte_valid_o && !byte_ready_i |=> byte_valid_o && $stable(byte_data_o))
    else $error("head byte changed while stalled");
  a_rx_once: assert property (rx_sample_valid_o[0] |=> !rx_sample_valid_o[0] [*8])
    else $error("receive sample pulses too close");
  a_ovr_sticky: assert property (overrun_o && !overrun_clr_i |=> overrun_o)
    else $error("overrun flag lost without clear");
endmodule // scph_checker

// File: testbench/scph_far_end.sv
`timescale 1ns/1ps
module scph_far_end (
  // clock
  input  wire clk_i,
  // control port
  output reg  ctl_clk_o,
  output reg  ctl_sel_n_o,
  output reg  ctl_si_o,
  input  wire ctl_so_i,
  input  wire ctl_so_oe_n_i,
  // pcm highways, transmit looped to receive
  output reg  bclk_o,
  output reg  fs_o,
  output reg  rx_a_o,
  output reg  rx_b_o,
  input  wire tx_a_i,
  input  wire tx_a_oe_n_i,
  input  wire tx_b_i,
  input  wire tx_b_oe_n_i
);
  reg       so_last;
  reg [2:0] ph;
  reg [7:0] bcnt;
  integer   i;
  // a released reply line shows the inverse, never a stale bit
  wire so_lvl = ctl_so_oe_n_i ? ~so_last : ctl_so_i;
  initial
  begin
    {ctl_clk_o, ctl_sel_n_o, ctl_si_o} = 3'h6;
    {bclk_o, fs_o, rx_a_o, rx_b_o, so_last, ph, bcnt} = 16'h0;
  end
  // bit clock 128 ns keeps within the accepted range; 256 bits a frame
  always @(negedge clk_i)
  begin
    so_last <= so_lvl;
    rx_a_o <= tx_a_oe_n_i ? ~rx_a_o : tx_a_i;
    rx_b_o <= tx_b_oe_n_i ? ~rx_b_o : tx_b_i;
    ph <= ph + 3'h1;
    if (ph == 3'h7)
    begin
      bclk_o <= ~bclk_o;
      if (!bclk_o)
      begin
        bcnt <= bcnt + 8'h01;
        fs_o <= (bcnt == 8'hFF);
      end
    end
  end
  // select change, then a quiet gap before any clock edge
  task sel(input reg v);
    begin
      @(negedge clk_i);
      ctl_sel_n_o = v;
      repeat (8) @(negedge clk_i);
    end
  endtask
  // one whole byte, msb first, clock idles high, 7.8 MHz
  task xfer(input [7:0] d, output [7:0] q);
    begin
      for (i = 7; i >= 0; i = i - 1)
      begin
        ctl_clk_o = 1'b0;
        ctl_si_o = d[i];
        repeat (8) @(negedge clk_i);
        ctl_clk_o = 1'b1;
        repeat (8) @(negedge clk_i);
        q[i] = so_lvl;
      end
    end
  endtask
endmodule // scph_far_end

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  reg         clk = 0, rst_n = 0, half = 0, fall = 0, lin = 0;
  reg         rdy = 0, oclr = 0, ren = 0, hold = 1;
  reg  [2:0]  dly = 0;
  reg  [7:0]  rdat = 0, q;
  reg  [27:0] txs = 0, rxs = 0;
  reg  [3:0]  txh = 0, rxh = 0;
  reg  [63:0] smp = 0;
  reg  [31:0] r;
  integer     seed = 59856, error_cnt = 0, n_compared = 0, k, w;
  reg  [8:0]  bq[$];
  reg  [15:0] pq[$];
  wire        cc, sn, si, so, soe, bv, bc, ovr, tk, bclk, fs, ra, rb, ta, tae, txb, tbe;
  wire        ian, iao, ibn, ibo;
  wire [7:0]  bd;
  wire [63:0] rs;
  wire [3:0]  rv;
  always #4 clk = ~clk;
  scph_top scph_top_i (.clk_i(clk), .rst_n_i(rst_n), .ctl_clk_i(cc), .ctl_sel_n_i(sn),
    .ctl_si_i(si), .ctl_so_o(so), .ctl_so_oe_n_o(soe), .byte_valid_o(bv), .byte_data_o(bd),
    .byte_is_cmd_o(bc), .byte_ready_i(rdy), .overrun_o(ovr), .overrun_clr_i(oclr),
    .reply_en_i(ren), .reply_data_i(rdat), .reply_taken_o(tk), .bclk_i(bclk), .fs_i(fs),
    .rx_a_i(ra), .rx_b_i(rb), .tx_a_o(ta), .tx_a_oe_n_o(tae), .tx_b_o(txb), .tx_b_oe_n_o(tbe),
    .ind_a_n_o(ian), .ind_a_oe_n_o(iao), .ind_b_n_o(ibn), .ind_b_oe_n_o(ibo), .half_rate_i(half),
    .fall_edge_i(fall), .slot_delay_i(dly), .linear_i(lin), .tx_slot_i(txs), .rx_slot_i(rxs),
    .tx_hwy_i(txh), .rx_hwy_i(rxh), .tx_sample_i(smp), .rx_sample_o(rs), .rx_sample_valid_o(rv));
  scph_far_end far_i (.clk_i(clk), .ctl_clk_o(cc), .ctl_sel_n_o(sn), .ctl_si_o(si),
    .ctl_so_i(so), .ctl_so_oe_n_i(soe), .bclk_o(bclk), .fs_o(fs), .rx_a_o(ra), .rx_b_o(rb),
    .tx_a_i(ta), .tx_a_oe_n_i(tae), .tx_b_i(txb), .tx_b_oe_n_i(tbe));
  ////////////////////////////////////////////////////////////////
  task chk(input [127:0] nm, input [15:0] e, input [15:0] g);
    begin
      n_compared = n_compared + 1;
      if (g !== e)
      begin
        error_cnt = error_cnt + 1;
        $display("unexpected %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // bounded wait for the user side to empty the byte notes
  task drain;
    begin
      for (w = 0; bq.size() > 0 && w < 4000; w = w + 1)
        @(negedge clk);
      chk("bytes left", 16'h0000, bq.size());
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // random stalls on the user side; reply dropped once loaded
  always @(negedge clk)
  begin
    r = $random(seed);
    rdy <= !hold & r[0];
    if (tk === 1'b1)
      ren <= 1'b0;
  end
  // byte notes popped as the user side takes them
  always @(posedge clk)
    if (bv === 1'b1 && rdy === 1'b1)
    begin
      if (bq.size() == 0)
        chk("spare byte", 16'hFFFF, {bc, bd});
      else
        chk("byte", bq.pop_front(), {bc, bd});
    end
  // indicator must be pulled low whenever its highway drives
  always @(negedge clk)
  begin
    if (tae === 1'b0)
      chk("ind a", 16'h0000, {iao, ian});
    if (tbe === 1'b0)
      chk("ind b", 16'h0000, {ibo, ibn});
  end
  // compressed result sits in the low byte only
  always @(posedge clk)
    if (rv[1] === 1'b1 && pq.size() > 0)
      chk("pcm", pq.pop_front(), lin ? rs[31:16] : {8'h00, rs[23:16]});
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(negedge clk);
    rst_n = 1;
    repeat (10) @(negedge clk);
    hold = 0;
    // command plus data, then clocks while deselected
    far_i.sel(0);
    for (k = 0; k < 3; k = k + 1)
    begin
      r = $random(seed);
      bq.push_back({k == 0, r[7:0]});
      far_i.xfer(r[7:0], q);
    end
    far_i.sel(1);
    far_i.xfer(8'hA5, q);
    // read: command, turnaround, reply while input is ignored
    far_i.sel(0);
    bq.push_back(9'h13C);
    far_i.xfer(8'h3C, q);
    rdat = r[15:8];
    ren = 1;
    bq.push_back(9'h000);
    far_i.xfer(8'h00, q);
    far_i.xfer(8'hFF, q);
    chk("reply", rdat, q);
    far_i.sel(1);
    drain;
    // fill the buffer past its depth while the user stalls
    hold = 1;
    far_i.sel(0);
    for (k = 0; k < 17; k = k + 1)
    begin
      r = $random(seed);
      if (k < 16)
        bq.push_back({k == 0, r[7:0]});
      far_i.xfer(r[7:0], q);
    end
    far_i.sel(1);
    chk("overrun", 16'h0001, ovr);
    hold = 0;
    drain;
    oclr = 1;
    @(negedge clk);
    oclr = 0;
    @(negedge clk);
    chk("overrun clr", 16'h0000, ovr);
    // pcm loopback: channel 0 sends, channel 1 receives the same slot
    for (k = 0; k < 4; k = k + 1)
    begin
      @(negedge clk);
      r = $random(seed);
      lin = k[0];
      half = k[1];
      fall = k[0] ^ k[1];
      dly = r[2:0];
      txh = {4{r[3]}};
      rxh = {4{r[3]}};
      txs = {21'h1FFFFF, 4'h0, lin ? {2'h0, r[4]} : r[6:4]};
      rxs = {14'h3FFF, 4'h0, lin ? {2'h0, r[4]} : r[6:4], 7'h7F};
      smp = {$random(seed), $random(seed)};
      @(posedge fs);
      @(posedge fs);
      pq.push_back(lin ? {{2{smp[13]}}, smp[13:0]} : {8'h00, smp[7:0]});
      for (w = 0; pq.size() > 0 && w < 9000; w = w + 1)
        @(negedge clk);
      chk("pcm left", 16'h0000, pq.size());
    end
    tally_and_finish;
  end
  // watchdog well past the expected run length
  initial
  begin
    #700000;
    error_cnt = error_cnt + 1;
    tally_and_finish;
  end
endmodule // tb_top
bind scph_top scph_checker #(.CH(CH)) scph_checker_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .ctl_sel_n_i(ctl_sel_n_i), .ctl_so_oe_n_o(ctl_so_oe_n_o), .byte_valid_o(byte_valid_o),
  .byte_data_o(byte_data_o), .byte_ready_i(byte_ready_i), .overrun_o(overrun_o),
  .overrun_clr_i(overrun_clr_i), .reply_taken_o(reply_taken_o), .tx_hwy_i(tx_hwy_i),
  .tx_a_oe_n_o(tx_a_oe_n_o), .tx_b_oe_n_o(tx_b_oe_n_o), .ind_a_n_o(ind_a_n_o),
  .ind_a_oe_n_o(ind_a_oe_n_o), .ind_b_oe_n_o(ind_b_oe_n_o), .rx_sample_valid_o(rx_sample_valid_o));
